// ### hbus_port.sv
/*
 * Host bus slave, DMA master cycles and remote data port handshake.
 * Assumes all inputs are synchronous to clk_sys and that the host
 * keeps its own timing obligations.
 */
// Notes on behaviour
// R1: register select decoded only when acknowledging
// R2: write acknowledge after strobes plus synchronisation
// R3: dual bus: acknowledge waits for DMA completion
// R4: missed grant setup slips DMA four clocks
// R5: remote one transfer, local DMA bursts
// R6: primed address cycles only before first transfer
// R7: byte bursts hold upper address until last
// R8: wait sampled in T3 extends cycle
// R9: memory limits wait states per bus rate
// R10: port request re-raised after latch write high
// R11: read acknowledge drops request; local may delay
// R12: host uses four selects, byte accesses
// R13: chip selects spaced four clocks apart
// R14: read acknowledge held high seven clocks
// R15: high address strobe precedes low strobe
// R16: acknowledge released on strobe removal; data released
`timescale 1ns/10ps
`default_nettype none
module hbus_port
import hbus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic dual_bus,
    input wire logic mode_32bit,
    input wire logic byte_mode,
    input wire logic chip_select_n,
    input wire logic slave_read_strobe_n,
    input wire logic slave_write_strobe_n,
    input wire logic [3:0] register_select,
    input wire logic [7:0] slave_data_in,
    input wire logic [7:0] reg_read_data,
    output logic ack_n,
    output logic [7:0] slave_data_out,
    output logic slave_data_oe_n,
    output logic reg_write,
    output logic reg_read,
    output logic [3:0] reg_index,
    output logic [7:0] reg_write_data,
    input wire logic local_dma_req,
    input wire logic remote_dma_req,
    input wire logic [7:0] burst_len,
    input wire logic [31:0] dma_address,
    input wire logic dma_write,
    input wire logic [15:0] dma_wdata,
    input wire logic [15:0] muxed_addr_data_in,
    output logic bus_request,
    input wire logic bus_grant,
    input wire logic ext_wait,
    output logic [15:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe_n,
    output logic [7:0] upper_address_byte,
    output logic upper_address_oe_n,
    output logic low_address_strobe,
    output logic high_address_strobe,
    output logic mem_read_n,
    output logic mem_write_n,
    output logic dma_xfer_done,
    output logic [15:0] dma_rdata,
    output logic dma_busy,
    input wire logic port_remote_write,
    input wire logic port_active,
    input wire logic read_ack_n,
    output logic data_port_request,
    output logic port_latch_write_n,
    output logic port_xfer_done
);
    import hbus_pkg::*;

    // -----------------------------------------------------------------
    // slave access
    // -----------------------------------------------------------------
    slave_state_t slv;
    logic sync_load;
    logic sync_done;
    logic access_low;
    logic dma_clear;
    dma_state_t dma;

    assign access_low = !chip_select_n &&
        (!slave_read_strobe_n || !slave_write_strobe_n);
    assign dma_clear = !dual_bus || (dma == DMA_IDLE);
    assign sync_load = (slv == SLV_IDLE) && access_low;

    hbus_counter sync_cnt
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .load(sync_load),
        .value(SYNC_CYCLES),
        .done(sync_done)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            slv <= SLV_IDLE;
            ack_n <= 1'b1;
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            reg_index <= 4'h0;
            reg_write_data <= DATA_RESET;
            slave_data_out <= DATA_RESET;
            slave_data_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            case (slv)
                SLV_IDLE:
                begin
                    if (access_low)
                        slv <= SLV_SYNC;
                end
                SLV_SYNC:
                begin
                    if (!access_low)
                        slv <= SLV_IDLE;
                    else if (sync_done && dma_clear) // R2 R3
                    begin
                        slv <= SLV_ACK;
                        ack_n <= 1'b0;
                        reg_index <= register_select; // R1
                        if (!slave_write_strobe_n)
                        begin
                            reg_write <= 1'b1;
                            reg_write_data <= slave_data_in;
                        end
                        else
                        begin
                            reg_read <= 1'b1;
                            slave_data_out <= reg_read_data;
                            slave_data_oe_n <= 1'b0;
                        end
                    end
                end
                SLV_ACK:
                begin
                    if (slave_read_strobe_n && slave_write_strobe_n)
                    begin
                        slv <= SLV_IDLE; // R16
                        ack_n <= 1'b1;
                        slave_data_oe_n <= 1'b1;
                    end
                end
                default:
                    slv <= SLV_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // dma master cycles
    // -----------------------------------------------------------------
    logic [7:0] remain;
    logic is_remote;
    logic [2:0] slip;
    logic last_xfer;
    logic slave_pending;

    assign last_xfer = (remain <= 8'h1) || is_remote; // R5
    assign slave_pending = (slv != SLV_IDLE) && dual_bus;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dma <= DMA_IDLE;
            remain <= BURST_RESET;
            is_remote <= 1'b0;
            slip <= 3'h0;
            bus_request <= 1'b0;
            dma_busy <= 1'b0;
            dma_xfer_done <= 1'b0;
            dma_rdata <= ADDR_RESET;
            muxed_addr_data_out <= ADDR_RESET;
            muxed_addr_data_oe_n <= 1'b1;
            upper_address_byte <= DATA_RESET;
            upper_address_oe_n <= 1'b1;
            low_address_strobe <= 1'b0;
            high_address_strobe <= 1'b0;
            mem_read_n <= 1'b1;
            mem_write_n <= 1'b1;
        end
        else if (ce)
        begin
            dma_xfer_done <= 1'b0;
            case (dma)
                DMA_IDLE:
                begin
                    if ((local_dma_req || remote_dma_req) && !slave_pending)
                    begin
                        dma <= DMA_REQ;
                        bus_request <= 1'b1;
                        dma_busy <= 1'b1;
                        is_remote <= !local_dma_req;
                        remain <= local_dma_req ? burst_len : 8'h01;
                    end
                end
                DMA_REQ:
                begin
                    if (bus_grant) // R4
                        dma <= mode_32bit ? DMA_P1 : DMA_T1;
                    else
                    begin
                        dma <= DMA_SLIP;
                        slip <= GRANT_SLIP_CYCLES - 3'h1;
                    end
                end
                DMA_SLIP:
                begin
                    if (slip != 3'h0)
                        slip <= slip - 3'h1;
                    else if (bus_grant) // R4
                        dma <= mode_32bit ? DMA_P1 : DMA_T1;
                    else
                        slip <= GRANT_SLIP_CYCLES - 3'h1;
                end
                DMA_P1: // R6
                begin
                    muxed_addr_data_out <= dma_address[31:16]; // R15
                    muxed_addr_data_oe_n <= 1'b0;
                    high_address_strobe <= 1'b1;
                    dma <= DMA_P2;
                end
                DMA_P2:
                begin
                    high_address_strobe <= 1'b0; // R15
                    dma <= DMA_P3;
                end
                DMA_P3:
                    dma <= DMA_P4;
                DMA_P4:
                    dma <= DMA_T1;
                DMA_T1:
                begin
                    muxed_addr_data_out <= dma_address[15:0];
                    muxed_addr_data_oe_n <= 1'b0;
                    upper_address_byte <= dma_address[15:8];
                    upper_address_oe_n <= 1'b0;
                    low_address_strobe <= 1'b1;
                    dma <= DMA_T2;
                end
                DMA_T2:
                begin
                    low_address_strobe <= 1'b0;
                    if (dma_write)
                    begin
                        muxed_addr_data_out <= dma_wdata;
                        mem_write_n <= 1'b0;
                    end
                    else
                    begin
                        muxed_addr_data_oe_n <= 1'b1;
                        mem_read_n <= 1'b0;
                    end
                    dma <= DMA_T3;
                end
                DMA_T3:
                begin
                    if (!ext_wait) // R8
                        dma <= DMA_T4;
                end
                DMA_T4:
                begin
                    mem_read_n <= 1'b1;
                    mem_write_n <= 1'b1;
                    muxed_addr_data_oe_n <= 1'b1;
                    dma_xfer_done <= 1'b1;
                    if (!dma_write)
                        dma_rdata <= muxed_addr_data_in;
                    if (last_xfer)
                    begin
                        dma <= DMA_IDLE;
                        bus_request <= 1'b0;
                        dma_busy <= 1'b0;
                        upper_address_oe_n <= 1'b1; // R7
                    end
                    else
                    begin
                        remain <= remain - 8'h1; // R5
                        upper_address_oe_n <= !byte_mode; // R7
                        dma <= DMA_T1; // R6
                    end
                end
                default:
                    dma <= DMA_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // remote data port handshake
    // -----------------------------------------------------------------
    port_state_t port;
    logic rec_load;
    logic rec_done;
    logic rack_seen;

    assign rec_load = (port == PORT_WAIT_XFER) && rack_seen
        && read_ack_n;

    hbus_counter rec_cnt
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .load(rec_load),
        .value(RACK_HIGH_MIN),
        .done(rec_done)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port <= PORT_IDLE;
            data_port_request <= 1'b0;
            port_latch_write_n <= 1'b1;
            port_xfer_done <= 1'b0;
            rack_seen <= 1'b0;
        end
        else if (ce)
        begin
            port_xfer_done <= 1'b0;
            case (port)
                PORT_IDLE:
                begin
                    if (port_active && !local_dma_req) // R11
                    begin
                        if (!port_latch_write_n)
                            port_latch_write_n <= 1'b1; // R10
                        else
                        begin
                            data_port_request <= 1'b1;
                            port <= PORT_REQ;
                        end
                    end
                end
                PORT_REQ:
                begin
                    if (!read_ack_n) // R11
                    begin
                        data_port_request <= 1'b0;
                        rack_seen <= 1'b1;
                        port <= PORT_WAIT_XFER;
                    end
                end
                PORT_WAIT_XFER:
                begin
                    if (read_ack_n && rack_seen)
                    begin
                        rack_seen <= 1'b0;
                        port_latch_write_n <= !port_remote_write;
                        port_xfer_done <= 1'b1;
                        port <= PORT_RECOVER;
                    end
                end
                PORT_RECOVER:
                begin
                    port_latch_write_n <= 1'b1; // R10
                    if (rec_done && !read_ack_n)
                        port <= PORT_RECOVER;
                    else if (rec_done)
                        port <= PORT_IDLE;
                end
                default:
                    port <= PORT_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### hbus_pkg.sv
/*
 * Constants and types shared by the host bus port of the network
 * controller. Assumes a single system bus clock domain.
 */
package hbus_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [3:0] SYNC_CYCLES = 4'h2;
    localparam logic [2:0] GRANT_SLIP_CYCLES = 3'h4;
    localparam logic [3:0] RACK_HIGH_MIN = 4'h7;
    localparam logic [3:0] CS_GAP_MIN = 4'h4;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] BURST_RESET = 8'h00;

    typedef enum logic [3:0] {
        DMA_IDLE,
        DMA_REQ,
        DMA_SLIP,
        DMA_P1,
        DMA_P2,
        DMA_P3,
        DMA_P4,
        DMA_T1,
        DMA_T2,
        DMA_T3,
        DMA_T4
    } dma_state_t;

    typedef enum logic [1:0] {
        SLV_IDLE,
        SLV_SYNC,
        SLV_ACK
    } slave_state_t;

    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_REQ,
        PORT_WAIT_XFER,
        PORT_RECOVER
    } port_state_t;
endpackage

// ### hbus_counter.sv
/*
 * Small down counter with load, used for synchronisation and
 * recovery delays. Assumes clock enable gates all state.
 */
`timescale 1ns/10ps
`default_nettype none
module hbus_counter
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [3:0] value,
    output logic done
);
    logic [3:0] count;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            count <= 4'h0;
        else if (ce)
        begin
            if (load)
                count <= value;
            else if (count != 4'h0)
                count <= count - 4'h1;
        end
    end

    assign done = (count == 4'h0) && !load;
endmodule
`default_nettype wire

// ### hbus_port_asserts.sv
/*
 * Timing checks on the host bus port pins.
 * Assumes bind to hbus_port with ce held high.
 */
`timescale 1ns/10ps
`default_nettype none
module hbus_port_asserts
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic dual_bus,
    input wire logic byte_mode,
    input wire logic chip_select_n,
    input wire logic slave_read_strobe_n,
    input wire logic slave_write_strobe_n,
    input wire logic [3:0] register_select,
    input wire logic ack_n,
    input wire logic slave_data_oe_n,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [3:0] reg_index,
    input wire logic bus_request,
    input wire logic bus_grant,
    input wire logic low_address_strobe,
    input wire logic high_address_strobe,
    input wire logic upper_address_oe_n,
    input wire logic dma_busy,
    input wire logic read_ack_n,
    input wire logic data_port_request,
    input wire logic port_latch_write_n
);
// ---------------------------------------------
// pin relations
// ---------------------------------------------
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (rst);
a_ack_after_sync: assert property ($fell(ack_n) |->
    $past(!chip_select_n && !(slave_read_strobe_n && slave_write_strobe_n),
    2)) else $error("ack too early");
a_ack_dma_first: assert property ($fell(ack_n) && dual_bus |->
    !dma_busy) else $error("ack during dma");
a_ack_release: assert property (!ack_n && slave_read_strobe_n
    && slave_write_strobe_n |-> ##[1:2] ack_n) else $error("ack stuck");
a_data_release: assert property ($rose(ack_n) |->
    slave_data_oe_n) else $error("data still driven");
a_decode_at_ack: assert property (reg_read |->
    !ack_n && $past(!slave_read_strobe_n)) else $error("decode off ack");
a_index_at_ack: assert property ($fell(ack_n) |->
    reg_index == $past(register_select)) else $error("index not latched");
a_strobe_at_ack: assert property ($fell(ack_n) |->
    reg_read || reg_write) else $error("no access pulse");
a_port_req_drop: assert property (data_port_request &&
    !read_ack_n |-> ##[1:2] !data_port_request) else $error("req held");
a_req_after_latch: assert property ($rose(data_port_request) |->
    port_latch_write_n) else $error("req during latch write");
a_high_before_low: assert property (high_address_strobe |->
    ##[1:8] low_address_strobe) else $error("no low strobe");
a_grant_slip: assert property ($rose(bus_request) ##1 !bus_grant
    |-> !(low_address_strobe || high_address_strobe) [*4])
    else $error("no slip");
a_upper_hold: assert property ($rose(upper_address_oe_n) &&
    byte_mode |-> ##[0:3] !dma_busy) else $error("upper released");
endmodule
bind hbus_port hbus_port_asserts i_hbus_port_asserts
(
    .clk_sys(clk_sys),
    .rst(rst),
    .dual_bus(dual_bus),
    .byte_mode(byte_mode),
    .chip_select_n(chip_select_n),
    .slave_read_strobe_n(slave_read_strobe_n),
    .slave_write_strobe_n(slave_write_strobe_n),
    .register_select(register_select),
    .ack_n(ack_n),
    .slave_data_oe_n(slave_data_oe_n),
    .reg_read(reg_read),
    .reg_write(reg_write),
    .reg_index(reg_index),
    .bus_request(bus_request),
    .bus_grant(bus_grant),
    .low_address_strobe(low_address_strobe),
    .high_address_strobe(high_address_strobe),
    .upper_address_oe_n(upper_address_oe_n),
    .dma_busy(dma_busy),
    .read_ack_n(read_ack_n),
    .data_port_request(data_port_request),
    .port_latch_write_n(port_latch_write_n)
);
`default_nettype wire

// ### mem_model.sv
/*
 * Arbiter and memory seen from the port's bus master side.
 * Assumes the bench sets grant_late and wait_states.
 */
`timescale 1ns/10ps
`default_nettype none
module mem_model
#(
    parameter logic [15:0] MEM_WORD = 16'hA5C3
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_request,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic grant_late,
    input wire logic [1:0] wait_states,
    output logic bus_grant,
    output logic ext_wait,
    output logic [15:0] muxed_addr_data_in
);
// ---------------------------------------------
// arbiter and wait logic
// ---------------------------------------------
logic [3:0] gcnt;
logic [2:0] wcnt;
logic strobe;
assign strobe = !mem_read_n || !mem_write_n;
always_ff @(posedge clk_sys)
begin
    if (rst || !bus_request)
        gcnt <= 4'h0;
    else if (gcnt != 4'hF)
        gcnt <= gcnt + 4'h1;
end
always_ff @(posedge clk_sys)
begin
    if (rst || !strobe)
        wcnt <= 3'h0;
    else if (wcnt != 3'h7)
        wcnt <= wcnt + 3'h1;
end
// late grant misses setup
assign bus_grant = bus_request && (!grant_late || gcnt >= 4'h3);
assign ext_wait = strobe && (wcnt < {1'b0, wait_states});
// released bus shows inverted data
assign muxed_addr_data_in = mem_read_n ? ~MEM_WORD : MEM_WORD;
endmodule
`default_nettype wire

// ### tb.sv
/*
 * Self-checking bench for the host bus port.
 * Assumes hbus_pkg, hbus_port and mem_model.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
import hbus_pkg::*;
localparam logic [15:0] RD_WORD = 16'hA5C3;
logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, dual_bus = 1'b0;
logic mode_32bit = 1'b0, byte_mode = 1'b0, chip_select_n = 1'b1;
logic slave_read_strobe_n = 1'b1, slave_write_strobe_n = 1'b1;
logic [3:0] register_select = 4'h0;
logic [7:0] slave_data_in = 8'h00, reg_read_data = 8'h5A;
logic ack_n, slave_data_oe_n, reg_write, reg_read;
logic [7:0] slave_data_out, reg_write_data, upper_address_byte;
logic [3:0] reg_index;
logic local_dma_req = 1'b0, remote_dma_req = 1'b0, dma_write = 1'b0;
logic [7:0] burst_len = 8'h01;
logic [31:0] dma_address = 32'h1234_5678;
logic [15:0] dma_wdata = 16'h0F96;
logic [15:0] muxed_addr_data_in, muxed_addr_data_out, dma_rdata;
logic bus_request, bus_grant, ext_wait, muxed_addr_data_oe_n;
logic upper_address_oe_n, low_address_strobe, high_address_strobe;
logic mem_read_n, mem_write_n, dma_xfer_done, dma_busy;
logic port_remote_write = 1'b0, port_active = 1'b0, read_ack_n = 1'b1;
logic data_port_request, port_latch_write_n, port_xfer_done;
logic grant_late = 1'b0;
logic [1:0] wait_states = 2'h0;
int num_errors = 0, n_compared = 0, t0, t1, l0, l2;
hbus_port i_hbus_port
(
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .dual_bus(dual_bus),
    .mode_32bit(mode_32bit),
    .byte_mode(byte_mode),
    .chip_select_n(chip_select_n),
    .slave_read_strobe_n(slave_read_strobe_n),
    .slave_write_strobe_n(slave_write_strobe_n),
    .register_select(register_select),
    .slave_data_in(slave_data_in),
    .reg_read_data(reg_read_data),
    .ack_n(ack_n),
    .slave_data_out(slave_data_out),
    .slave_data_oe_n(slave_data_oe_n),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_index(reg_index),
    .reg_write_data(reg_write_data),
    .local_dma_req(local_dma_req),
    .remote_dma_req(remote_dma_req),
    .burst_len(burst_len),
    .dma_address(dma_address),
    .dma_write(dma_write),
    .dma_wdata(dma_wdata),
    .muxed_addr_data_in(muxed_addr_data_in),
    .bus_request(bus_request),
    .bus_grant(bus_grant),
    .ext_wait(ext_wait),
    .muxed_addr_data_out(muxed_addr_data_out),
    .muxed_addr_data_oe_n(muxed_addr_data_oe_n),
    .upper_address_byte(upper_address_byte),
    .upper_address_oe_n(upper_address_oe_n),
    .low_address_strobe(low_address_strobe),
    .high_address_strobe(high_address_strobe),
    .mem_read_n(mem_read_n),
    .mem_write_n(mem_write_n),
    .dma_xfer_done(dma_xfer_done),
    .dma_rdata(dma_rdata),
    .dma_busy(dma_busy),
    .port_remote_write(port_remote_write),
    .port_active(port_active),
    .read_ack_n(read_ack_n),
    .data_port_request(data_port_request),
    .port_latch_write_n(port_latch_write_n),
    .port_xfer_done(port_xfer_done)
);
mem_model #(.MEM_WORD(RD_WORD)) i_mem_model
(
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_request(bus_request),
    .mem_read_n(mem_read_n),
    .mem_write_n(mem_write_n),
    .grant_late(grant_late),
    .wait_states(wait_states),
    .bus_grant(bus_grant),
    .ext_wait(ext_wait),
    .muxed_addr_data_in(muxed_addr_data_in)
);
always #12.5 clk_sys = ~clk_sys;
// ---------------------------------------------
// shared tasks
// ---------------------------------------------
task final_report;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
        num_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task need(input logic c);
    if (c !== 1'b1)
    begin
        num_errors++;
        $display("BAD t=%0t wait %h %h", $time, c, 1'b1);
        final_report();
    end
endtask
task reg_access(input bit wr, input logic [3:0] sel, input logic [7:0] d);
    int n;
    register_select = sel;
    slave_data_in = d;
    chip_select_n = 1'b0;
    slave_write_strobe_n = !wr;
    slave_read_strobe_n = wr;
    for (n = 0; ack_n !== 1'b0 && n < 300; n++) @(negedge clk_sys);
    need(!ack_n);
    chk(n > SYNC_CYCLES, 1);
    chk(reg_index, sel);
    chk(slave_data_oe_n, wr);
    chk(reg_write, wr);
    chk(reg_read, !wr);
    if (dual_bus) chk(dma_busy, 0);
    if (wr) chk(reg_write_data, d);
    else chk(slave_data_out, reg_read_data);
    slave_write_strobe_n = 1'b1;
    slave_read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(ack_n, 1);
    chk(slave_data_oe_n, 1);
    repeat (CS_GAP_MIN) @(negedge clk_sys);
endtask
// ---------------------------------------------
// scenarios
// ---------------------------------------------
task dma_run(input bit loc, input logic [7:0] len, input bit m32,
    input bit bm, input bit late, input bit wr, input logic [1:0] ws,
    output int ts, output int lr);
    int n, nd, nh, nl, ub, bad;
    nd = 0;
    nh = 0;
    nl = 0;
    ub = 0;
    bad = 0;
    ts = 0;
    lr = 0;
    burst_len = len;
    mode_32bit = m32;
    byte_mode = bm;
    grant_late = late;
    dma_write = wr;
    wait_states = ws;
    local_dma_req = loc;
    remote_dma_req = !loc;
    for (n = 0; bus_request !== 1'b1 && n < 20; n++) @(negedge clk_sys);
    local_dma_req = 1'b0;
    remote_dma_req = 1'b0;
    need(bus_request);
    for (n = 0; n < 300 && (n < 3 || dma_busy || dma_xfer_done); n++)
    begin
        if (high_address_strobe &&
            muxed_addr_data_out !== dma_address[31:16])
            bad++;
        if (low_address_strobe &&
            (muxed_addr_data_out !== dma_address[15:0] ||
            upper_address_byte !== dma_address[15:8] ||
            muxed_addr_data_oe_n !== 1'b0))
            bad++;
        if (low_address_strobe && nl == 0) ts = n;
        nl += low_address_strobe;
        nh += high_address_strobe;
        nd += dma_xfer_done;
        lr += !mem_read_n;
        if (dma_xfer_done && nd < len && bm && upper_address_oe_n) ub++;
        if (!mem_write_n && muxed_addr_data_out[7:0] !== dma_wdata[7:0])
            bad++;
        @(negedge clk_sys);
    end
    need(!dma_busy);
    chk(nd, loc ? len : 8'h01);
    chk(nh, m32);
    chk(nl, nd);
    chk(ub, 0);
    chk(bad, 0);
    if (!wr) chk(dma_rdata, RD_WORD);
    repeat (2) @(negedge clk_sys);
    chk(upper_address_oe_n, 1);
endtask
task dual_check;
    int n;
    dual_bus = 1'b1;
    burst_len = 8'h04;
    wait_states = 2'h2;
    local_dma_req = 1'b1;
    for (n = 0; dma_busy !== 1'b1 && n < 20; n++) @(negedge clk_sys);
    local_dma_req = 1'b0;
    need(dma_busy);
    reg_access(1'b0, 4'h3, 8'h00);
    for (n = 0; dma_busy && n < 300; n++) @(negedge clk_sys);
    need(!dma_busy);
    dual_bus = 1'b0;
    wait_states = 2'h0;
endtask
task port_xfer(input bit wr);
    int n;
    int nx;
    logic lat;
    lat = 1'b0;
    nx = 0;
    port_remote_write = wr;
    port_active = 1'b1;
    for (n = 0; data_port_request !== 1'b1 && n < 20; n++)
        @(negedge clk_sys);
    need(data_port_request);
    read_ack_n = 1'b0;
    @(negedge clk_sys);
    read_ack_n = 1'b1;
    for (n = 0; n < 40 && (n < 3 || !data_port_request); n++)
    begin
        if (!port_latch_write_n) lat = 1'b1;
        nx += port_xfer_done;
        if (n == 2) chk(data_port_request, 0);
        @(negedge clk_sys);
    end
    need(data_port_request);
    chk(lat, wr);
    chk(nx, 1);
    chk(n >= RACK_HIGH_MIN, 1);
    port_active = 1'b0;
    read_ack_n = 1'b0;
    @(negedge clk_sys);
    read_ack_n = 1'b1;
    repeat (2 * RACK_HIGH_MIN) @(negedge clk_sys);
endtask
initial
begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk(ack_n, 1);
    chk(slave_data_oe_n, 1);
    reg_access(1'b0, 4'hA, 8'h00);
    reg_access(1'b1, 4'h5, 8'hC3);
    dma_run(1'b0, 8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, t0, l0);
    dma_run(1'b0, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, t1, l0);
    chk(t1 - t0, GRANT_SLIP_CYCLES);
    dma_run(1'b1, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, t0, l0);
    dma_run(1'b1, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2, t0, l2);
    chk(l2 > l0, 1);
    dma_run(1'b1, 8'h03, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, t0, l0);
    dual_check();
    port_xfer(1'b1);
    port_xfer(1'b0);
    final_report();
end
endmodule
`default_nettype wire
